/* File: rtl/twbpe_top.v */
// Two-wire bus protocol engine: master byte engine and full-rate bus listener
// How it works
// - START: data line falls while clock line is high.
// - STOP: data line rises while clock line is high, ending the transfer.
// - Driven data line stays unchanged for the whole clock-high time.
// - Except START/STOP/RESTART, the data line changes only while clock is low.
// - 7-bit first byte: address in bits 7:1, direction in bit 0.
// - Direction 0 makes a master write, direction 1 a master read.
// - 10-bit first byte: prefix 11110, address bits 9:8, direction; then bits 7:0.
// - All-zero write first byte is general call: pass data on, raise interrupt.
// - First bytes carrying the CBUS code are ignored in either direction.
// - Reserved first-byte codes are never blocked from software use.
// - Whole bytes, any number of them between START and STOP.
// - Master transmitter aborts with STOP when the slave does not acknowledge.
// - Master receiver acknowledges every byte except the last one.
// - Instead of STOP the master may RESTART after the acknowledge pulse.
// - As listener the bus is sampled at full rate, so no START BYTE needed.
// - Master can prefix a transfer begun from an idle bus, not a RESTART, with a START BYTE sequence.
// - START BYTE: START, 0000 0001, unanswered acknowledge clock, RESTART.
`include "twbpe_map.vh"

module twbpe_top (
  // Clock and reset
  input  wire       CLK,
  input  wire       SYS_RST,
  // Byte command port
  input  wire       CMD_VALID,
  output wire       CMD_READY,
  input  wire       CMD_START,
  input  wire       CMD_STOP,
  input  wire       CMD_LAST,
  input  wire [7:0] CMD_DATA,
  input  wire       START_BYTE_EN,
  // Results
  output reg        DONE,
  output reg        ACK_ERR,
  output reg  [7:0] RX_DATA,
  output reg        RX_VALID,
  output wire       BUS_BUSY,
  // General call
  output reg  [7:0] GC_DATA,
  output reg        GC_VALID,
  output reg        GC_IRQ,
  // Bus pins, open drain
  input  wire       SCL_I,
  output wire       SCL_O,
  output wire       SCL_OE,
  input  wire       SDA_I,
  output wire       SDA_O,
  output wire       SDA_OE
);

  localparam integer QTR_INT = `TWBPE_QTR_CYC - 1;
  localparam [`TWBPE_QCNT_W-1:0] QTR_LAST = QTR_INT[`TWBPE_QCNT_W-1:0];

  // Pin synchronisers and edge history
  reg        scl_m_ff;
  reg        scl_s_ff;
  reg        scl_d_ff;
  reg        sda_m_ff;
  reg        sda_s_ff;
  reg        sda_d_ff;

  // Master engine
  reg  [2:0] state_ff;
  reg  [1:0] phase_ff;
  reg  [3:0] bit_ff;
  reg  [`TWBPE_QCNT_W-1:0] qcnt_ff;
  reg  [7:0] sh_ff;
  reg  [7:0] data_ff;
  reg        last_ff;
  reg        stop_ff;
  reg        sbyte_ff;
  reg        addr_ff;
  reg        read_ff;
  reg        scl_low_ff;
  reg        sda_low_ff;
  reg        nxt_scl_low;
  reg        nxt_sda_low;

  // Bus listener
  reg  [1:0] lstate_ff;
  reg  [3:0] lcnt_ff;
  reg  [7:0] lsh_ff;
  reg        busy_ff;
  reg        lack_ff;

  wire       start_det;
  wire       stop_det;
  wire       scl_rise;
  wire       scl_fall;
  wire       own;
  wire       wait_scl;
  wire       tick;
  wire       cmd_fire;
  wire [7:0] lbyte;

  // Both pins synchronised at the full system rate
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      scl_m_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_m_ff <= SCL_I;
      scl_s_ff <= scl_m_ff;
      scl_d_ff <= scl_s_ff;
      sda_m_ff <= SDA_I;
      sda_s_ff <= sda_m_ff;
      sda_d_ff <= sda_s_ff;
    end
  end

  assign start_det = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;
  assign stop_det  = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;
  assign scl_rise  = scl_s_ff & ~scl_d_ff;
  assign scl_fall  = ~scl_s_ff & scl_d_ff;

  assign own       = (state_ff != `TWBPE_M_IDLE);
  assign BUS_BUSY  = busy_ff;
  // Pins only ever pull low; the pull-ups make the high level
  assign SCL_O     = 1'b0;
  assign SDA_O     = 1'b0;
  assign SCL_OE    = scl_low_ff;
  assign SDA_OE    = sda_low_ff | lack_ff;

  // A slave stretching the clock keeps the quarter count at zero until the line is seen high
  assign wait_scl  = own & (phase_ff == 2'h2) & ~scl_low_ff & ~scl_s_ff;
  assign tick      = (qcnt_ff == QTR_LAST) & ~wait_scl;
  assign CMD_READY = ((state_ff == `TWBPE_M_IDLE) & ~busy_ff) | (state_ff == `TWBPE_M_HOLD);
  assign cmd_fire  = CMD_VALID & CMD_READY;

  // Pin levels per state and quarter
  always @* begin
    nxt_scl_low = scl_low_ff;
    nxt_sda_low = sda_low_ff;
    case (state_ff)
      `TWBPE_M_START: begin
        // Release data a few cycles into the clock-low quarter, then pull it with clock high
        nxt_scl_low = (phase_ff == 2'h0);
        nxt_sda_low = phase_ff[1];
        if ((phase_ff == 2'h0) && sda_low_ff && !qcnt_ff[3])
          nxt_sda_low = 1'b1;
      end
      `TWBPE_M_BYTE: begin
        nxt_scl_low = ~phase_ff[1];
        // Data moves only in the second low quarter, so it is settled before the rise
        if (phase_ff == 2'h1) begin
          if (bit_ff != `TWBPE_ACK_BIT)
            nxt_sda_low = ~read_ff & ~sh_ff[7];
          else
            nxt_sda_low = read_ff & ~last_ff;
        end
      end
      `TWBPE_M_HOLD: nxt_scl_low = 1'b1;
      `TWBPE_M_STOP: begin
        nxt_scl_low = ~phase_ff[1];
        if (phase_ff == 2'h1)
          nxt_sda_low = 1'b1;
        else if (phase_ff == 2'h3)
          nxt_sda_low = 1'b0;
      end
      default: begin
        nxt_scl_low = 1'b0;
        nxt_sda_low = 1'b0;
      end
    endcase
  end

  // Master engine
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_ff   <= `TWBPE_M_IDLE;
      phase_ff   <= 2'h0;
      bit_ff     <= 4'h0;
      qcnt_ff    <= {`TWBPE_QCNT_W{1'b0}};
      sh_ff      <= 8'h00;
      data_ff    <= 8'h00;
      last_ff    <= 1'b0;
      stop_ff    <= 1'b0;
      sbyte_ff   <= 1'b0;
      addr_ff    <= 1'b0;
      read_ff    <= 1'b0;
      scl_low_ff <= 1'b0;
      sda_low_ff <= 1'b0;
      DONE       <= 1'b0;
      ACK_ERR    <= 1'b0;
      RX_DATA    <= 8'h00;
      RX_VALID   <= 1'b0;
    end else begin
      scl_low_ff <= nxt_scl_low;
      sda_low_ff <= nxt_sda_low;
      DONE       <= 1'b0;
      ACK_ERR    <= 1'b0;
      RX_VALID   <= 1'b0;
      if (wait_scl || tick || !own)
        qcnt_ff <= {`TWBPE_QCNT_W{1'b0}};
      else
        qcnt_ff <= qcnt_ff + 1'b1;
      if (cmd_fire) begin
        // Reserved first-byte codes pass through untouched
        data_ff  <= CMD_DATA;
        last_ff  <= CMD_LAST;
        stop_ff  <= CMD_STOP;
        qcnt_ff  <= {`TWBPE_QCNT_W{1'b0}};
        bit_ff   <= 4'h0;
        if (state_ff == `TWBPE_M_IDLE) begin
          // Bus was idle with both lines high: skip the clock-low quarter
          state_ff <= `TWBPE_M_START;
          phase_ff <= 2'h1;
          sbyte_ff <= START_BYTE_EN;
        end else if (CMD_START) begin
          state_ff <= `TWBPE_M_START;
          phase_ff <= 2'h0;
        end else begin
          state_ff <= `TWBPE_M_BYTE;
          phase_ff <= 2'h0;
          sh_ff    <= CMD_DATA;
        end
      end else if (own && tick && state_ff != `TWBPE_M_HOLD) begin
        phase_ff <= phase_ff + 2'h1;
        if (phase_ff == 2'h3) begin
          case (state_ff)
            `TWBPE_M_START: begin
              state_ff <= `TWBPE_M_BYTE;
              bit_ff   <= 4'h0;
              addr_ff  <= ~sbyte_ff;
              read_ff  <= 1'b0;
              // The START BYTE goes out first, the address after the RESTART
              sh_ff    <= sbyte_ff ? `TWBPE_SBYTE : data_ff;
            end
            `TWBPE_M_BYTE: begin
              if (bit_ff != `TWBPE_ACK_BIT) begin
                sh_ff  <= {sh_ff[6:0], sda_s_ff};
                bit_ff <= bit_ff + 4'h1;
              end else if (sbyte_ff) begin
                // Acknowledge clock of the START BYTE is not examined
                sbyte_ff <= 1'b0;
                state_ff <= `TWBPE_M_START;
              end else if (!read_ff && sda_s_ff) begin
                ACK_ERR  <= 1'b1;
                state_ff <= `TWBPE_M_STOP;
              end else begin
                DONE    <= 1'b1;
                addr_ff <= 1'b0;
                // Direction comes from bit 0 of the byte after START; a 10-bit
                // write first byte keeps the next address byte a write
                if (addr_ff)
                  read_ff <= data_ff[0];
                if (read_ff) begin
                  RX_DATA  <= sh_ff;
                  RX_VALID <= 1'b1;
                end
                if (stop_ff || (read_ff && last_ff))
                  state_ff <= `TWBPE_M_STOP;
                else
                  state_ff <= `TWBPE_M_HOLD;
              end
            end
            default: state_ff <= `TWBPE_M_IDLE;
          endcase
        end
      end
    end
  end

  // Bus listener, run at the full system rate on every edge it sees
  assign lbyte = {lsh_ff[6:0], sda_s_ff};
  always @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      lstate_ff <= `TWBPE_L_IDLE;
      lcnt_ff   <= 4'h0;
      lsh_ff    <= 8'h00;
      busy_ff   <= 1'b0;
      lack_ff   <= 1'b0;
      GC_DATA   <= 8'h00;
      GC_VALID  <= 1'b0;
      GC_IRQ    <= 1'b0;
    end else begin
      GC_VALID <= 1'b0;
      GC_IRQ   <= 1'b0;
      if (start_det) begin
        // Any START or RESTART resets the receive state
        busy_ff   <= 1'b1;
        lcnt_ff   <= 4'h0;
        lack_ff   <= 1'b0;
        lstate_ff <= own ? `TWBPE_L_IGNORE : `TWBPE_L_ADDR;
      end else if (stop_det) begin
        busy_ff   <= 1'b0;
        lack_ff   <= 1'b0;
        lstate_ff <= `TWBPE_L_IDLE;
      end else begin
        if (scl_fall) begin
          if (lack_ff)
            lack_ff <= 1'b0;
          else if (lcnt_ff == `TWBPE_ACK_BIT && lstate_ff == `TWBPE_L_GCALL)
            lack_ff <= 1'b1;
        end
        if (scl_rise) begin
          if (lcnt_ff == `TWBPE_ACK_BIT) begin
            lcnt_ff <= 4'h0;
          end else begin
            lsh_ff  <= lbyte;
            lcnt_ff <= lcnt_ff + 4'h1;
            if (lcnt_ff == 4'h7) begin
              case (lstate_ff)
                `TWBPE_L_ADDR: begin
                  if (lbyte == `TWBPE_GCALL_BYTE) begin
                    GC_IRQ    <= 1'b1;
                    lstate_ff <= `TWBPE_L_GCALL;
                  end else if (lbyte[7:1] == `TWBPE_CBUS_ADDR) begin
                    lstate_ff <= `TWBPE_L_IGNORE;
                  end else begin
                    // START BYTE, 10-bit prefixes and plain addresses are not ours
                    lstate_ff <= `TWBPE_L_IGNORE;
                  end
                end
                `TWBPE_L_GCALL: begin
                  GC_DATA  <= lbyte;
                  GC_VALID <= 1'b1;
                end
                default: lstate_ff <= lstate_ff;
              endcase
            end
          end
        end
      end
    end
  end

endmodule

/* File: rtl/twbpe_map.vh */
// Timing counts, first-byte codes and state codes of the two-wire protocol engine
`ifndef TWBPE_MAP_VH
`define TWBPE_MAP_VH

// System clock rate in MHz
`define TWBPE_CLK_MHZ      10
// Quarter of a 100 kHz SCL period, in ns
`define TWBPE_QTR_NS       2500
// Quarter period in clock cycles, a least time so rounded up
`define TWBPE_QTR_CYC      ((`TWBPE_QTR_NS * `TWBPE_CLK_MHZ + 999) / 1000)
`define TWBPE_QCNT_W       5

// First-byte codes
`define TWBPE_GCALL_BYTE   8'h00
`define TWBPE_CBUS_ADDR    7'h01
`define TWBPE_SBYTE        8'h01
`define TWBPE_TENBIT_PFX   5'h1e

// Bit index of the acknowledge slot
`define TWBPE_ACK_BIT      4'h8

// Master states
`define TWBPE_M_IDLE       3'h0
`define TWBPE_M_START      3'h1
`define TWBPE_M_BYTE       3'h2
`define TWBPE_M_HOLD       3'h3
`define TWBPE_M_STOP       3'h4

// Bus listener states
`define TWBPE_L_IDLE       2'h0
`define TWBPE_L_ADDR       2'h1
`define TWBPE_L_GCALL      2'h2
`define TWBPE_L_IGNORE     2'h3

`endif

/* File: verification/twbpe_chk.sv */
// Pin-level protocol checker for the two-wire protocol engine
module twbpe_chk (
  // Clock and reset
  input wire CLK,
  input wire SYS_RST,
  // Results
  input wire ACK_ERR,
  input wire BUS_BUSY,
  input wire GC_IRQ,
  // Bus
  input wire SCL_I,
  input wire SCL_OE,
  input wire SDA_I,
  input wire SDA_OE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  AST_START_HOLD: assert property ($rose(SDA_OE) && !SCL_OE && SCL_I |-> !SCL_OE [*8])
    else $error("clock pulled low too soon after start");
  AST_STOP_HOLD: assert property ($fell(SDA_OE) && !SCL_OE && SCL_I |-> !SDA_OE [*8])
    else $error("data pulled again right after stop");
  AST_DATA_STABLE: assert property ($fell(SCL_OE) |-> $stable(SDA_OE) [*8])
    else $error("data moved while clock high");
  AST_DATA_HOLD: assert property ($rose(SCL_OE) |-> $stable(SDA_OE) [*8])
    else $error("data moved without hold after clock fall");
  AST_ABORT_STOP: assert property (ACK_ERR |-> ##[1:400] $fell(SDA_OE) && !SCL_OE)
    else $error("no stop after missing acknowledge");
  AST_BUSY_SET: assert property ($fell(SDA_I) && SCL_I && $past(SCL_I) |-> ##[1:6] BUS_BUSY)
    else $error("start not seen as busy");
  AST_BUSY_CLR: assert property ($rose(SDA_I) && SCL_I && $past(SCL_I) |-> ##[1:6] !BUS_BUSY)
    else $error("stop did not free the bus");
  AST_GC_ACK: assert property (GC_IRQ |-> ##[0:60] SDA_OE)
    else $error("general call not acknowledged");
endmodule

bind twbpe_top twbpe_chk twbpe_chk_inst (
  .CLK(CLK), .SYS_RST(SYS_RST), .ACK_ERR(ACK_ERR), .BUS_BUSY(BUS_BUSY), .GC_IRQ(GC_IRQ),
  .SCL_I(SCL_I), .SCL_OE(SCL_OE), .SDA_I(SDA_I), .SDA_OE(SDA_OE));

/* File: verification/twbpe_slave.sv */
// Bus slave model: fixed 7-bit address or any 10-bit prefix, logs bytes
module twbpe_slave #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  // Bus levels
  input  wire  scl,
  input  wire  sda,
  // Pulls data low
  output logic oe
);
  timeunit 1ns;
  timeprecision 1ns;
  int          bc;
  int          starts;
  int          stops;
  bit          first;
  bit          hit;
  bit          rd;
  bit          mack;
  logic [7:0]  sh;
  logic [7:0]  tx;
  logic [31:0] log;
  logic [3:0]  mk;
  initial oe = 0;
  always @(negedge sda) if (scl === 1'b1) begin
    bc = 0;
    first = 1;
    hit = 0;
    oe <= 0;
    starts++;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    hit = 0;
    stops++;
  end
  always @(posedge scl) begin
    if (bc < 8) sh = {sh[6:0], sda};
    else mack = !sda;
    bc++;
  end
  // Drive only after the clock falls, so data never moves while it is high
  always @(negedge scl) begin
    if (bc == 8) begin
      log = {log[23:0], sh};
      if (first) begin
        hit = sh[7:1] == ADDR || sh[7:3] == 5'h1e;
        rd = sh[0];
        tx = 8'h5a;
      end
      oe <= hit && (first || !rd);
    end else if (bc == 9) begin
      bc = 0;
      if (!first && rd && hit) begin
        mk = {mk[2:0], mack};
        hit = mack;
        tx++;
      end
      first = 0;
      oe <= hit && rd && !tx[7];
    end else oe <= hit && rd && !first && bc > 0 && !tx[7 - bc];
  end
endmodule

/* File: verification/test_two_wire_bus_protocol_engine.sv */
// Self-checking bench for the two-wire protocol engine
module test_two_wire_bus_protocol_engine;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 0, rst = 1, vld = 0, st = 0, sp = 0, lst = 0, sben = 0;
  logic       m_scl = 0, m_sda = 0, r_err, r_v;
  logic [7:0] dat = 0, r_rx, gc_last;
  wire        rdy, done, aerr, rxv, busy, gcv, gci, scl_oe, sda_oe, s_oe, scl_o, sda_o;
  wire  [7:0] rxd, gcd;
  wire        scl = !(scl_oe | m_scl);
  wire        sda = !(sda_oe | s_oe | m_sda);
  int         errors, checks_done, cyc, gc_n;
  bit   [1:0] ak;
  twbpe_top twbpe_top_inst (
    .CLK(clk), .SYS_RST(rst), .CMD_VALID(vld), .CMD_READY(rdy), .CMD_START(st),
    .CMD_STOP(sp), .CMD_LAST(lst), .CMD_DATA(dat), .START_BYTE_EN(sben), .DONE(done),
    .ACK_ERR(aerr), .RX_DATA(rxd), .RX_VALID(rxv), .BUS_BUSY(busy), .GC_DATA(gcd),
    .GC_VALID(gcv), .GC_IRQ(gci), .SCL_I(scl), .SCL_O(scl_o), .SCL_OE(scl_oe), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE(sda_oe));
  twbpe_slave slv (.scl(scl), .sda(sda), .oe(s_oe));
  always #50 clk = ~clk;
  always @(posedge clk) begin
    if (gci === 1'b1) gc_n <= gc_n + 1;
    if (gcv === 1'b1) gc_last <= gcd;
  end
  task automatic results;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Ceiling well above the sum of all transfers
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      results();
    end
  end
  task automatic ck(input bit ok, input string m);
    checks_done++;
    if (!ok) begin
      errors++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  task automatic cmd(input bit s, p, l, input logic [7:0] d);
    int n;
    @(negedge clk);
    {st, sp, lst, dat, vld} = {s, p, l, d, 1'b1};
    n = 0;
    while (rdy !== 1'b1 && n++ < 2000) @(negedge clk);
    @(negedge clk);
    vld = 0;
    n = 0;
    while (done !== 1'b1 && aerr !== 1'b1 && n++ < 4000) @(negedge clk);
    r_err = aerr;
    r_rx = rxd;
    r_v = rxv;
    ck(n < 4000, "no answer");
  endtask
  task automatic idle(input string t);
    int n;
    n = 0;
    while (!(rdy === 1'b1 && busy === 1'b0) && n++ < 1000) @(negedge clk);
    ck(n < 1000, "bus not freed");
    $display("%s done", t);
  endtask
  task automatic clr;
    slv.log = 0;
    slv.starts = 0;
    slv.stops = 0;
  endtask
  task automatic t_write;
    clr();
    cmd(1, 0, 0, 8'h54);
    cmd(0, 0, 0, 8'h3c);
    cmd(0, 1, 0, 8'hc3);
    idle("write");
    ck(slv.log === 32'h00543cc3 && r_err === 1'b0, "write bytes");
    ck(slv.starts == 1 && slv.stops == 1, "write framing");
    ck(r_v === 1'b0, "read strobe on a write byte");
    ck(scl_o === 1'b0 && sda_o === 1'b0, "pins must only pull low");
  endtask
  task automatic t_read;
    clr();
    cmd(1, 0, 0, 8'h55);
    cmd(0, 0, 0, 8'h00);
    ck(r_rx === 8'h5a && r_v === 1'b1, "first read byte");
    cmd(0, 0, 1, 8'h00);
    ck(r_rx === 8'h5b && r_v === 1'b1, "last read byte");
    idle("read");
    ck(slv.mk[1:0] === 2'b10 && slv.stops == 1, "read acks");
  endtask
  task automatic t_nack;
    logic [7:0] a[2] = '{8'h66, 8'h04};
    foreach (a[i]) begin
      clr();
      cmd(1, 0, 0, a[i]);
      idle("nack");
      ck(r_err === 1'b1 && slv.log[7:0] === a[i], "address refused");
      ck(slv.stops == 1, "abort stop");
    end
  endtask
  task automatic t_restart;
    clr();
    cmd(1, 0, 0, 8'h54);
    cmd(0, 0, 0, 8'h11);
    cmd(1, 0, 0, 8'h55);
    cmd(0, 0, 1, 8'h00);
    idle("restart");
    ck(r_rx === 8'h5a && slv.log === 32'h5411555a, "combined bytes");
    ck(slv.starts == 2 && slv.stops == 1, "restart framing");
  endtask
  task automatic t_ten;
    clr();
    cmd(1, 0, 0, 8'hf4);
    cmd(0, 1, 0, 8'h9c);
    idle("tenbit");
    ck(slv.log === 32'h0000f49c && r_err === 1'b0, "ten-bit address");
  endtask
  task automatic t_sbyte;
    clr();
    sben = 1;
    cmd(1, 1, 0, 8'h54);
    sben = 0;
    idle("sbyte");
    ck(slv.log === 32'h00000154 && r_err === 1'b0, "start byte");
    ck(slv.starts == 2, "start byte restart");
  endtask
  task automatic mbit(input bit b, output bit r);
    m_scl = 1;
    @(negedge clk);
    m_sda = !b;
    repeat (3) @(negedge clk);
    m_scl = 0;
    repeat (4) @(negedge clk);
    r = sda;
  endtask
  // Second master on the bus, 800 ns clock period
  task automatic mxfer(input logic [15:0] d, input int nb, output bit [1:0] a);
    bit r;
    @(negedge clk);
    m_sda = 1;
    repeat (4) @(negedge clk);
    for (int k = 0; k < nb; k++) begin
      for (int i = 15; i >= 8; i--) mbit(d[i], r);
      mbit(1, r);
      a[1 - k] = !r;
      d = d << 8;
    end
    mbit(0, r);
    m_sda = 0;
    repeat (20) @(negedge clk);
  endtask
  task automatic t_gc;
    int n0;
    n0 = gc_n;
    mxfer(16'h003c, 2, ak);
    ck(ak === 2'b11 && gc_n == n0 + 1 && gc_last === 8'h3c, "general call");
    mxfer(16'h0300, 1, ak);
    ck(ak[1] === 1'b0 && gc_n == n0 + 1, "cbus ignored");
    $display("gcall done");
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst = 0;
    t_write();
    t_read();
    t_nack();
    t_restart();
    t_ten();
    t_sbyte();
    t_gc();
    results();
  end
endmodule
